// ===== common/rafs_pkg.sv
// ==========================================================================
// Shared constants and types for the request agent flush status block
// ==========================================================================
package rafs_pkg;

  // ========================================================================
  // Bus shape
  // ========================================================================
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // ========================================================================
  // Register byte offsets
  // ========================================================================
  localparam logic [4:0] OFF_CAP_STAT = 5'h04;
  localparam logic [4:0] OFF_ERR_LOG = 5'h08;
  localparam logic [4:0] OFF_CONTROL = 5'h0C;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h10;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h14;

  // ========================================================================
  // Field positions
  // ========================================================================
  localparam int CAP_PRECISE_BIT = 18;
  localparam int CAP_COUNT_LSB = 19;
  localparam int CAP_EXP_LSB = 28;
  localparam int CAP_DONE_BIT = 31;
  localparam int CTRL_FLUSH_BIT = 14;
  localparam int LOG_LSB = 20;
  localparam int LOG_W = 12;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_LATE_BIT = 1;
  localparam int IRQ_CLEAR_BIT = 2;
  localparam int IRQ_W = 3;

  // ========================================================================
  // Reset values and write masks
  // ========================================================================
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_4000;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // ========================================================================
  // Timing
  // ========================================================================
  localparam longint unsigned CLK_PERIOD_NS = 64'd40;
  localparam int FLUSH_BASE_SHIFT = 5;
  localparam int TIMER_W = 40;

  // Register request as seen by the decode logic
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } rafs_bus_req_s;

  // Flush sequencer states
  typedef enum logic [1:0] {
    FL_IDLE = 2'b00,
    FL_BUSY = 2'b01,
    FL_LATE = 2'b11,
    FL_DONE = 2'b10
  } rafs_flush_e;

endpackage

// ===== hw/rafs_sync2.sv
`timescale 1ns/1ps
// ==========================================================================
// Two flip-flop level synchroniser
// ==========================================================================
module rafs_sync2 (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r; // First stage, read only by the second
  logic sync_r; // Settled copy

  // Both stages clear at reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// ===== hw/rafs_flush_engine.sv
`timescale 1ns/1ps
// ==========================================================================
// Flush sequencer: enable edges, cache handshake, deadline timer
// ==========================================================================
module rafs_flush_engine #(
  parameter logic [8:0] FLUSH_COUNT = 9'h064,
  parameter logic [2:0] FLUSH_EXP = 3'h1
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic flush_enable,
  input wire logic cache_ack,
  output logic cache_flush_req,
  output logic flush_done,
  output logic done_pulse,
  output logic late_pulse
);

  // Reported time in ns, then cycles rounded down, never below one
  localparam longint unsigned LIMIT_NS =
    64'(FLUSH_COUNT) *
    (64'd1 << (rafs_pkg::FLUSH_BASE_SHIFT * int'(FLUSH_EXP)));
  localparam longint unsigned LIMIT_RAW = LIMIT_NS / rafs_pkg::CLK_PERIOD_NS;
  localparam longint unsigned LIMIT_CYC = (LIMIT_RAW == 0) ? 1 : LIMIT_RAW;
  localparam logic [39:0] LIMIT = 40'(LIMIT_CYC);

  rafs_pkg::rafs_flush_e state_r; // Sequencer state
  rafs_pkg::rafs_flush_e state_nxt;
  logic en_d_r; // Enable one cycle late, for edges
  logic [39:0] timer_r; // Cycles spent waiting for the cache
  logic [39:0] timer_nxt;
  logic flag_r;
  logic req_r;
  logic done_p_r;
  logic late_p_r;

  wire rise = flush_enable & ~en_d_r;
  wire fall = ~flush_enable & en_d_r;
  wire at_limit = (timer_r == LIMIT - 40'h1);

  // ========================================================================
  // Next state
  // ========================================================================
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rafs_pkg::FL_IDLE: begin
        if (rise) begin
          state_nxt = rafs_pkg::FL_BUSY;
        end
      end
      rafs_pkg::FL_BUSY: begin
        if (fall) begin
          state_nxt = rafs_pkg::FL_IDLE;
        end else if (cache_ack) begin
          state_nxt = rafs_pkg::FL_DONE;
        end else if (at_limit) begin
          state_nxt = rafs_pkg::FL_LATE;
        end
      end
      rafs_pkg::FL_LATE: begin
        // Overdue: keep asking, the flag still rises if the cache ends
        if (fall) begin
          state_nxt = rafs_pkg::FL_IDLE;
        end else if (cache_ack) begin
          state_nxt = rafs_pkg::FL_DONE;
        end
      end
      rafs_pkg::FL_DONE: begin
        if (fall) begin
          state_nxt = rafs_pkg::FL_IDLE;
        end
      end
      default: begin
        state_nxt = rafs_pkg::FL_IDLE;
      end
    endcase
  end

  // Timer runs only while the cache is inside its budget
  assign timer_nxt = (state_r == rafs_pkg::FL_BUSY) ?
                     timer_r + 40'h1 : 40'h0;

  // ========================================================================
  // State and output flops
  // ========================================================================
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= rafs_pkg::FL_IDLE;
      en_d_r <= 1'b0;
      timer_r <= 40'h0;
      flag_r <= 1'b0;
      req_r <= 1'b0;
      done_p_r <= 1'b0;
      late_p_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      en_d_r <= flush_enable;
      timer_r <= timer_nxt;
      flag_r <= (state_nxt == rafs_pkg::FL_DONE);
      req_r <= state_nxt[0]; // BUSY and LATE both ask
      done_p_r <= (state_nxt == rafs_pkg::FL_DONE) &
                  (state_r != rafs_pkg::FL_DONE);
      late_p_r <= (state_nxt == rafs_pkg::FL_LATE) &
                  (state_r == rafs_pkg::FL_BUSY);
    end
  end

  assign cache_flush_req = req_r;
  assign flush_done = flag_r;
  assign done_pulse = done_p_r;
  assign late_pulse = late_p_r;

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_enable_rise;
    !flush_enable ##1 flush_enable;
  endsequence

  a_flush_start_req: assert property (
    (s_enable_rise ##0 state_r == rafs_pkg::FL_IDLE) |=> cache_flush_req
  ) else $error("flush request not raised after enable rise");

  a_ack_sets_done: assert property (
    (flush_enable && en_d_r && cache_ack &&
     state_r == rafs_pkg::FL_BUSY) |=> (flush_done && done_pulse)
  ) else $error("cache ack did not set done flag");

  a_fall_clears: assert property (
    $fell(flush_enable) |=> (!flush_done && !cache_flush_req)
  ) else $error("done flag survived enable fall");

  a_late_exact: assert property (
    (state_r == rafs_pkg::FL_BUSY && flush_enable && !cache_ack &&
     at_limit) |=> late_pulse
  ) else $error("deadline not flagged at reported time");

endmodule

// ===== hw/rafs_top.sv
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - Bit 18 reports precise snoop state capability
// - Bits 27:19 hold nine-bit flush count
// - Bits 30:28 select 32^n ns multiplier
// - Flush time is count times multiplier
// - Flush time fields valid from the start
// - Bit 31 reads one once flush completes
// - Done set within reported time after enable rises; done waits for the cache ack, past that time the late event fires
// - Enable falling clears the done bit
// - Reset clears done bit, function reset keeps it
// - Offset 08h holds error log offset only
// - While enabled, write back, invalidate, keep snooping
module rafs_top #(
  parameter logic PRECISE_CAP = 1'b1,
  parameter logic [8:0] FLUSH_COUNT = 9'h064,
  parameter logic [2:0] FLUSH_EXP = 3'h1,
  parameter logic [11:0] ERR_LOG_OFFSET = 12'h100
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic function_level_reset,
  output logic cache_flush_req,
  input wire logic cache_flush_ack
);

  // ========================================================================
  // Declarations
  // ========================================================================
  rafs_pkg::rafs_bus_req_s req; // Bundled bus request
  logic wait_r; // Waitrequest, high when idle
  logic [31:0] rdata_r; // Read data, loaded one edge before accept
  logic [31:0] ctrl_r; // Control register, holds the flush request
  logic [31:0] ctrl_nxt;
  logic [2:0] istat_r; // Sticky event bits
  logic [2:0] istat_nxt;
  logic [2:0] imask_r; // Interrupt enables, same layout
  logic [2:0] imask_nxt;
  logic irq_r; // Registered interrupt level
  logic flr_sync; // Function reset after the synchroniser
  logic flr_d_r; // For the rising edge of function reset
  logic flush_done; // Completion flag from the sequencer
  logic done_pulse;
  logic late_pulse;
  logic en_d_r; // Flush request bit delayed, for the clear event

  // ========================================================================
  // Bus request decode
  // ========================================================================
  assign req.rd = avs_read;
  assign req.wr = avs_write;
  assign req.addr = avs_address;
  assign req.wdata = avs_writedata;
  assign req.be = avs_byteenable;

  // A request is accepted on the edge where waitrequest is low
  wire accept = (req.rd | req.wr) & ~wait_r;
  wire wr_acc = accept & req.wr;
  wire rd_acc = accept & req.rd;

  // Address hits
  wire hit_cap = (req.addr == rafs_pkg::OFF_CAP_STAT);
  wire hit_log = (req.addr == rafs_pkg::OFF_ERR_LOG);
  wire hit_ctrl = (req.addr == rafs_pkg::OFF_CONTROL);
  wire hit_istat = (req.addr == rafs_pkg::OFF_IRQ_STAT);
  wire hit_imask = (req.addr == rafs_pkg::OFF_IRQ_MASK);

  // Byte enables widened to a bit mask
  wire [31:0] be_mask = {{8{req.be[3]}}, {8{req.be[2]}},
                         {8{req.be[1]}}, {8{req.be[0]}}};

  // ========================================================================
  // Register read views
  // ========================================================================
  // Capability fields are parameters, so they are valid from reset on
  wire [31:0] cap_word =
    (32'(flush_done) << rafs_pkg::CAP_DONE_BIT) |
    (32'(FLUSH_EXP) << rafs_pkg::CAP_EXP_LSB) |
    (32'(FLUSH_COUNT) << rafs_pkg::CAP_COUNT_LSB) |
    (32'(PRECISE_CAP) << rafs_pkg::CAP_PRECISE_BIT);

  // Only the log offset field is populated, the rest reads zero
  wire [31:0] log_word =
    32'(ERR_LOG_OFFSET) << rafs_pkg::LOG_LSB;

  // Read multiplexer; unmapped offsets read zero
  wire [31:0] rd_word =
    hit_cap ? cap_word :
    hit_log ? log_word :
    hit_ctrl ? ctrl_r :
    hit_istat ? {29'h0, istat_r} :
    hit_imask ? {29'h0, imask_r} : 32'h0000_0000;

  // ========================================================================
  // Register write views
  // ========================================================================
  // Only the flush request bit and the interrupt mask are writable; capability, status and log
  // pointer have no write path at all
  wire ctrl_we = wr_acc & hit_ctrl;
  wire [31:0] ctrl_wm = rafs_pkg::CTRL_WMASK & be_mask;
  assign ctrl_nxt = ctrl_we ?
    ((ctrl_r & ~ctrl_wm) | (req.wdata & ctrl_wm)) : ctrl_r;

  wire flush_en = ctrl_r[rafs_pkg::CTRL_FLUSH_BIT];

  // ========================================================================
  // Interrupt bookkeeping
  // ========================================================================
  // Function reset: edge of the synchronised pin
  wire flr_pulse = flr_sync & ~flr_d_r;

  // Events: flush done, flush overdue, flush cleared by software
  wire clr_event = ~flush_en & en_d_r;
  wire [2:0] events = {clr_event, late_pulse, done_pulse};

  // A read of the status clears it, but an event in the same cycle survives a racing read
  // or a function reset; an event one edge earlier, after the read data was loaded, is cleared unread
  wire istat_rc = rd_acc & hit_istat;
  assign istat_nxt = (flr_pulse ? rafs_pkg::IRQ_RST :
                      (istat_rc ? 3'h0 : istat_r)) | events;

  // Mask takes byte lane 0 only
  wire imask_we = wr_acc & hit_imask & req.be[0];
  assign imask_nxt = flr_pulse ? rafs_pkg::IRQ_RST :
                     imask_we ? req.wdata[2:0] : imask_r;

  // ========================================================================
  // Submodules
  // ========================================================================
  // Function reset arrives from outside this clock
  rafs_sync2 u_flr_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(function_level_reset),
    .sync_out(flr_sync)
  );

  // Sequencer owns the done flag; function reset never reaches it
  rafs_flush_engine #(
    .FLUSH_COUNT(FLUSH_COUNT),
    .FLUSH_EXP(FLUSH_EXP)
  ) u_engine (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .flush_enable(flush_en),
    .cache_ack(cache_flush_ack),
    .cache_flush_req(cache_flush_req),
    .flush_done(flush_done),
    .done_pulse(done_pulse),
    .late_pulse(late_pulse)
  );

  // ========================================================================
  // Bus handshake
  // ========================================================================
  // One wait cycle per access: the read data is loaded at the edge
  // that drops waitrequest, so it stands at the accept edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~((req.rd | req.wr) & wait_r);
      if (req.rd & wait_r) begin
        rdata_r <= rd_word;
      end
    end
  end

  // ========================================================================
  // Control register
  // ========================================================================
  // Function reset leaves control alone, so a running flush continues
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= rafs_pkg::CTRL_RST;
      en_d_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      en_d_r <= flush_en;
    end
  end

  // ========================================================================
  // Interrupt registers
  // ========================================================================
  // Level output lags the status by one edge to stay a flop output
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      istat_r <= rafs_pkg::IRQ_RST;
      imask_r <= rafs_pkg::IRQ_RST;
      irq_r <= 1'b0;
      flr_d_r <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      irq_r <= |(istat_r & imask_r);
      flr_d_r <= flr_sync;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign irq = irq_r;

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_cap_read;
    rd_acc && hit_cap;
  endsequence

  sequence s_cap_write;
    wr_acc && hit_cap;
  endsequence

  a_cap_precise: assert property (
    s_cap_read |-> avs_readdata[18] == PRECISE_CAP
  ) else $error("precise snoop bit reads wrong");

  a_cap_count: assert property (
    s_cap_read |-> avs_readdata[27:19] == FLUSH_COUNT
  ) else $error("flush count field reads wrong");

  a_cap_exponent: assert property (
    s_cap_read |-> avs_readdata[30:28] == FLUSH_EXP
  ) else $error("flush exponent field reads wrong");

  a_done_status: assert property (
    s_cap_read |-> avs_readdata[31] == $past(flush_done)
  ) else $error("done bit does not follow the flag");

  a_log_pointer: assert property (
    (rd_acc && hit_log) |->
      avs_readdata == {ERR_LOG_OFFSET, 20'h0_0000}
  ) else $error("error log pointer reads wrong");

  a_ro_write: assert property (
    s_cap_write |=> ($stable(ctrl_r) && $stable(flush_done))
  ) else $error("write to capability changed state");

  a_flr_keeps: assert property (
    flr_pulse |=> $stable(flush_done)
  ) else $error("function reset disturbed done flag");

  a_enable_done: assert property (
    (flush_en && cache_flush_ack && cache_flush_req && !flush_done)
      |-> ##[1:2] flush_done
  ) else $error("done flag late after cache ack");

  a_flush_clear: assert property (
    (flush_done && !ctrl_nxt[14] && ctrl_we) |-> ##2 !flush_done
  ) else $error("done flag not cleared with enable");

  a_wait_one: assert property (
    ((req.rd || req.wr) && wait_r) |=> !avs_waitrequest
  ) else $error("access not answered after one wait");

endmodule

// ===== verification/rafs_top_tb.sv
`timescale 1ns/1ps
// ==========================================================================
// Register level testbench for the flush status block
// ==========================================================================
module rafs_top_tb;
  // Short flush time so a deadline is a few cycles: 4 * 32 ns = 128 ns
  localparam logic [8:0] CNT = 9'h004;
  localparam logic [2:0] EXP = 3'h1;
  localparam logic [11:0] LOG_OFF = 12'h100;
  // Deadline in whole clock cycles, rounded down (3 here)
  localparam int DL = (int'(CNT) * (32 ** int'(EXP))) / 40;
  // Expected capability word with the done bit low
  localparam logic [31:0] CAP_EXP = (32'h1 << rafs_pkg::CAP_PRECISE_BIT)
    | ({23'h0, CNT} << rafs_pkg::CAP_COUNT_LSB)
    | ({29'h0, EXP} << rafs_pkg::CAP_EXP_LSB);
  localparam logic [31:0] DONE_B = 32'h1 << rafs_pkg::CAP_DONE_BIT;
  localparam logic [31:0] FL_B = 32'h1 << rafs_pkg::CTRL_FLUSH_BIT;

  // ========================================================================
  // Stimulus and observed signals
  // ========================================================================
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic function_level_reset = 1'b0;
  logic cache_flush_req;
  logic cache_flush_ack = 1'b0;
  logic [31:0] rd; // Last word read
  int n_errors = 0;
  int checks_done = 0;

  // ========================================================================
  // Clock and device
  // ========================================================================
  // 25 MHz: invert every 20 ns
  always #20 ref_clk = ~ref_clk;

  rafs_top #(
    .PRECISE_CAP(1'b1),
    .FLUSH_COUNT(CNT),
    .FLUSH_EXP(EXP),
    .ERR_LOG_OFFSET(LOG_OFF)
  ) dut (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .irq(irq),
    .function_level_reset(function_level_reset),
    .cache_flush_req(cache_flush_req),
    .cache_flush_ack(cache_flush_ack)
  );

  // ========================================================================
  // Helpers
  // ========================================================================
  // Compare and count; four-state compare so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for the accepting edge; a hung slave counts as a mismatch
  task automatic wait_accept();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_errors++;
      $display("wrong value at %0t: no bus answer", $time);
    end
  endtask

  // Avalon write, held until waitrequest is sampled low
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d,
                        input logic [3:0] be);
    @(posedge ref_clk);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    wait_accept();
    avs_write <= 1'b0;
  endtask

  // Avalon read; data taken at the accepting edge
  task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    avs_read <= 1'b1;
    avs_address <= a;
    avs_byteenable <= 4'hF;
    wait_accept();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  // Read and compare in one call
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    bus_rd(a, rd);
    check(rd, exp);
  endtask

  // Bounded wait for the cache request, then acknowledge it
  task automatic ack_flush();
    int n;
    n = 0;
    while (cache_flush_req !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h0, cache_flush_req}, 32'h1);
    cache_flush_ack <= 1'b1;
    repeat (2) @(posedge ref_clk);
    cache_flush_ack <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check({31'h0, cache_flush_req}, 32'h0);
  endtask

  // Single closing point of the run
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ========================================================================
  // Watchdog: the whole sequence needs well under a thousand cycles
  // ========================================================================
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    final_report();
  end

  // ========================================================================
  // Test sequence
  // ========================================================================
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    // Reset values and reserved space
    rd_chk(rafs_pkg::OFF_CAP_STAT, CAP_EXP);
    rd_chk(rafs_pkg::OFF_ERR_LOG, {LOG_OFF, 20'h0});
    rd_chk(rafs_pkg::OFF_CONTROL, 32'h0);
    rd_chk(5'h18, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test done: reset values");

    // Writes to read-only places and to other control bits change nothing
    bus_wr(rafs_pkg::OFF_CAP_STAT, 32'hFFFF_FFFF, 4'hF);
    bus_wr(rafs_pkg::OFF_ERR_LOG, 32'hFFFF_FFFF, 4'hF);
    bus_wr(rafs_pkg::OFF_CONTROL, ~FL_B, 4'hF);
    // Flush bit lives in byte lane 1, so lane 0 alone cannot set it
    bus_wr(rafs_pkg::OFF_CONTROL, FL_B, 4'h1);
    rd_chk(rafs_pkg::OFF_CAP_STAT, CAP_EXP);
    rd_chk(rafs_pkg::OFF_ERR_LOG, {LOG_OFF, 20'h0});
    rd_chk(rafs_pkg::OFF_CONTROL, 32'h0);
    check({31'h0, cache_flush_req}, 32'h0);
    $display("test done: read-only fields");

    // Prompt flush: acknowledged well inside the deadline
    bus_wr(rafs_pkg::OFF_IRQ_MASK, 32'h7, 4'hF);
    bus_wr(rafs_pkg::OFF_CONTROL, FL_B, 4'hF);
    ack_flush();
    rd_chk(rafs_pkg::OFF_CAP_STAT, CAP_EXP | DONE_B);
    check({31'h0, irq}, 32'h1);
    // Only the done event: no overdue flag inside the deadline
    rd_chk(rafs_pkg::OFF_IRQ_STAT, 32'h1);
    repeat (3) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    rd_chk(rafs_pkg::OFF_IRQ_STAT, 32'h0);
    $display("test done: prompt flush");

    // Clearing the enable drops the done bit
    bus_wr(rafs_pkg::OFF_CONTROL, 32'h0, 4'hF);
    repeat (3) @(posedge ref_clk);
    rd_chk(rafs_pkg::OFF_CAP_STAT, CAP_EXP);
    rd_chk(rafs_pkg::OFF_IRQ_STAT, 32'h4);
    $display("test done: enable cleared");

    // Late flush with all events masked: overdue seen, irq stays low
    bus_wr(rafs_pkg::OFF_IRQ_MASK, 32'h0, 4'hF);
    bus_wr(rafs_pkg::OFF_CONTROL, FL_B, 4'hF);
    repeat (DL + 6) @(posedge ref_clk);
    rd_chk(rafs_pkg::OFF_CAP_STAT, CAP_EXP);
    rd_chk(rafs_pkg::OFF_IRQ_STAT, 32'h2);
    check({31'h0, irq}, 32'h0);
    ack_flush();
    rd_chk(rafs_pkg::OFF_CAP_STAT, CAP_EXP | DONE_B);
    rd_chk(rafs_pkg::OFF_IRQ_STAT, 32'h1);
    $display("test done: late flush");

    // Function level reset keeps the done bit and the control register
    bus_wr(rafs_pkg::OFF_IRQ_MASK, 32'h7, 4'hF);
    @(posedge ref_clk);
    function_level_reset <= 1'b1;
    repeat (6) @(posedge ref_clk);
    function_level_reset <= 1'b0;
    rd_chk(rafs_pkg::OFF_CAP_STAT, CAP_EXP | DONE_B);
    rd_chk(rafs_pkg::OFF_CONTROL, FL_B);
    rd_chk(rafs_pkg::OFF_IRQ_MASK, 32'h0);
    $display("test done: function reset");

    // A full reset in mid-run clears the done bit and the control bit
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    rd_chk(rafs_pkg::OFF_CAP_STAT, CAP_EXP);
    rd_chk(rafs_pkg::OFF_CONTROL, 32'h0);
    check({31'h0, cache_flush_req}, 32'h0);
    $display("test done: full reset");
    final_report();
  end
endmodule
